// ==== ldsc_device.sv ====
// Device end: serial configuration word receiver and port settings register
`timescale 1ns/1ps

// Frame on the link, first bit first, one bit per rising link clock:
//   bit 0       start, low
//   bit 1       start, high
//   bit 2       select port A
//   bit 3       select port B
//   bits 4, 5   power mode, high bit first
//   bits 6..9   bias code, most significant first
//   bit 10      parity, high when bits 2..9 hold an even count of ones
//   bit 11      stop, high
// The link has no return path, so the result pulses are the only sign that a
// word was dropped; a host that must know has to watch them.
// Settings only change on a complete, well-formed word, never part-way through
// one, so a port never sees a mix of old and new fields.
module ldsc_device
  import ldsc_pkg::*;
(
  // Link side, clocked by the host's link clock
  ldsc_if.device         link,
  // Reset, synchronous to the link clock
  input  wire logic       RST_B_I,
  // Port A settings
  output ldsc_mode_t      MODE_A_O,
  output logic [3:0]      BIAS_A_O,
  // Port B settings
  output ldsc_mode_t      MODE_B_O,
  output logic [3:0]      BIAS_B_O,
  // Pulse on each applied word, and on each rejected word
  output logic            WORD_OK_O,
  output logic            WORD_BAD_O
);
  // Receiver states
  typedef enum logic [1:0]
  {
    ST_IDLE  = 2'b00,
    ST_START = 2'b01,
    ST_BITS  = 2'b10
  } ldsc_rx_st_t;

  typedef struct packed
  {
    ldsc_rx_st_t st;
    logic [3:0]  cnt;
    logic [8:0]  sh;
    ldsc_mode_t  mode_a;
    logic [3:0]  bias_a;
    ldsc_mode_t  mode_b;
    logic [3:0]  bias_b;
    logic        ok;
    logic        bad;
  } ldsc_dev_t;

  ldsc_dev_t r;
  ldsc_dev_t next_r;
  logic [9:0] word;   // Bits 2..11 of the word, bit 2 at index 0
  logic       good;
  // Fields of the word as it completes, meaningful only at the stop bit
  logic       sel_a;
  logic       sel_b;
  ldsc_mode_t word_mode;
  logic [3:0] word_bias;

  // Index of a frame bit within the collected word, which starts at bit 2
  function automatic int word_idx(input int pos);
  begin
    word_idx = pos - POS_SEL_A;
  end
  endfunction

  // Odd parity over bits 2..10 and a high stop bit; either fault drops the word
  function automatic logic frame_good(input logic [9:0] w);
  begin
    frame_good = (w[word_idx(POS_PARITY)] == parity_bit(w[7:0]))
                 && w[word_idx(POS_STOP)];
  end
  endfunction

  // Select bit of one port, taken from its frame position
  function automatic logic port_sel(input logic [9:0] w, input int pos);
  begin
    port_sel = w[word_idx(pos)];
  end
  endfunction

  // Power mode, bit 4 as the high bit
  function automatic ldsc_mode_t mode_of(input logic [9:0] w);
  begin
    mode_of = ldsc_mode_t'({w[word_idx(POS_MODE_HI)], w[word_idx(POS_MODE_LO)]});
  end
  endfunction

  // Bias code, bit 6 as the most significant and bit 9 as the least
  function automatic logic [3:0] bias_of(input logic [9:0] w);
  begin
    bias_of = {w[word_idx(POS_BIAS_MSB)],
               w[word_idx(POS_BIAS_MSB) + 1],
               w[word_idx(POS_BIAS_LSB) - 1],
               w[word_idx(POS_BIAS_LSB)]};
  end
  endfunction

  // Frame decoder. The host stops the link clock between words, so the receiver cannot
  // time out a cut frame on its own; it takes the next word's bits, start pair included, as the rest of that frame,
  // and a reset clears a frame that was cut short.
  always_comb
  begin
    next_r = r;
    next_r.ok = 1'b0;
    next_r.bad = 1'b0;
    word = {link.link_data, r.sh};
    good = frame_good(word);
    sel_a = port_sel(word, POS_SEL_A);
    sel_b = port_sel(word, POS_SEL_B);
    word_mode = mode_of(word);
    word_bias = bias_of(word);
    case (r.st)
      // Waiting for the low start bit
      ST_IDLE:
      begin
        if (!link.link_data)
          next_r.st = ST_START;
      end
      // Waiting for the high start bit
      ST_START:
      begin
        if (link.link_data)
        begin
          next_r.st = ST_BITS;
          next_r.cnt = 4'h0;
        end
        else
          next_r.st = ST_START;                        // Repeated low: still a candidate
      end
      // Collecting bits 2..11; the word is judged as the stop bit arrives
      ST_BITS:
      begin
        next_r.sh = {link.link_data, r.sh[8:1]};       // LSB first shift, bit 2 lands low
        next_r.cnt = r.cnt + 4'h1;
        if (r.cnt == 4'(POS_STOP - POS_SEL_A))
        begin
          next_r.st = ST_IDLE;
          next_r.ok = good;
          next_r.bad = ~good;
          // A rejected word and a word with no port selected both store nothing
          if (good && sel_a)
          begin
            next_r.mode_a = word_mode;
            next_r.bias_a = word_bias;
          end
          if (good && sel_b)
          begin
            next_r.mode_b = word_mode;
            next_r.bias_b = word_bias;
          end
        end
      end
      default:
        next_r.st = ST_IDLE;
    endcase
  end

  // State register; power-down with zero bias after reset
  // The reset is sampled on the link clock, so it only takes hold while that clock
  // runs; the host must toggle it during reset with the data line held high.
  always_ff @(posedge link.link_clk)
  begin
    if (!RST_B_I)
    begin
      r.st <= ST_IDLE;
      r.cnt <= 4'h0;
      r.sh <= 9'h000;
      r.mode_a <= ldsc_mode_t'(PORT_SET_RESET[5:4]);
      r.bias_a <= PORT_SET_RESET[3:0];
      r.mode_b <= ldsc_mode_t'(PORT_SET_RESET[5:4]);
      r.bias_b <= PORT_SET_RESET[3:0];
      r.ok <= 1'b0;
      r.bad <= 1'b0;
    end
    else
      r <= next_r;
  end

  // Outputs straight from the register; the result pulses last until the next
  // link clock edge, as the clock stops between words
  assign MODE_A_O = r.mode_a;
  assign BIAS_A_O = r.bias_a;
  assign MODE_B_O = r.mode_b;
  assign BIAS_B_O = r.bias_b;
  assign WORD_OK_O = r.ok;
  assign WORD_BAD_O = r.bad;
endmodule

// ==== ldsc_pkg.sv ====
// Package: shared constants and types for the serial configuration link
package ldsc_pkg;
  // Word framing and field positions (bit index in transmission order)
  localparam int WORD_BITS     = 12;
  localparam int POS_START0    = 0;
  localparam int POS_START1    = 1;
  localparam int POS_SEL_A     = 2;
  localparam int POS_SEL_B     = 3;
  localparam int POS_MODE_HI   = 4;
  localparam int POS_MODE_LO   = 5;
  localparam int POS_BIAS_MSB  = 6;
  localparam int POS_BIAS_LSB  = 9;
  localparam int POS_PARITY    = 10;
  localparam int POS_STOP      = 11;
  // Reset value of each port's settings (mode, bias)
  localparam logic [5:0] PORT_SET_RESET = 6'h00;
  // Power modes
  typedef enum logic [1:0]
  {
    MODE_POWER_DOWN = 2'b00,
    MODE_LINE_TERM  = 2'b01,
    MODE_AB_NO_H    = 2'b10,
    MODE_AB_BOOST   = 2'b11
  } ldsc_mode_t;
  // Host register offsets (Avalon byte addresses)
  localparam logic [3:0] REG_CMD    = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  // Command register fields
  localparam int CMD_SEL_A_POS  = 0;
  localparam int CMD_SEL_B_POS  = 1;
  localparam int CMD_MODE_POS   = 2;
  localparam int CMD_BIAS_POS   = 4;
  localparam int CMD_BADPAR_POS = 8;
  // Host link clock divider: half period in system clocks, keeping the link period at 200 ns or more
  localparam int CLK_PERIOD_NS  = 25;
  localparam int LINK_PERIOD_NS = 200;
  localparam int LINK_HALF_CYC  = (LINK_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
  // Odd parity bit value for a payload: 0 if ones count is odd, 1 if even
  function automatic logic parity_bit(input logic [7:0] payload);
    parity_bit = ~(^payload);
  endfunction
endpackage

// ==== ldsc_if.sv ====
// Interface: two-wire serial configuration link between host and device
`timescale 1ns/1ps
interface ldsc_if;
  logic link_clk;
  logic link_data;
  modport host   (output link_clk, output link_data);
  modport device (input link_clk, input link_data);
endinterface

// ==== ldsc_host.sv ====
// Host end: Avalon-MM command registers driving the serial link transmitter
`timescale 1ns/1ps
module ldsc_host
  import ldsc_pkg::*;
#(
  parameter int HALF_CYC = LINK_HALF_CYC
)
(
  // Clock and synchronous active-low reset
  input  wire logic        CLK_I,
  input  wire logic        RST_B_I,
  // Avalon-MM slave
  input  wire logic [3:0]  AVS_ADDRESS_I,
  input  wire logic        AVS_READ_I,
  input  wire logic        AVS_WRITE_I,
  input  wire logic [31:0] AVS_WRITEDATA_I,
  output logic [31:0]      AVS_READDATA_O,
  output logic             AVS_WAITREQUEST_O,
  // Serial link
  ldsc_if.host             link
);
  // Divider is eight bits wide; refuse half periods it cannot count
  if (HALF_CYC < 1 || HALF_CYC > 255)
  begin : g_half_cyc_bad
    $error("HALF_CYC out of range");
  end

  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_LOW  = 2'b01,
    ST_HIGH = 2'b10
  } ldsc_tx_st_t;

  typedef struct packed
  {
    ldsc_tx_st_t st;
    logic [7:0]  div;
    logic [3:0]  bit_n;
    logic [11:0] word;
    logic        lclk;
    logic        ldat;
    logic [31:0] rdata;
    logic        wait_n;
    logic [8:0]  last_cmd;
  } ldsc_host_t;

  ldsc_host_t r;
  ldsc_host_t next_r;
  logic       busy;
  logic [7:0] pay;

  // Bus slave and transmitter; a command write while busy waits until the word is out
  always_comb
  begin
    next_r = r;
    next_r.wait_n = 1'b0;
    busy = (r.st != ST_IDLE);
    pay = {AVS_WRITEDATA_I[CMD_BIAS_POS +: 4], AVS_WRITEDATA_I[CMD_MODE_POS +: 2],
           AVS_WRITEDATA_I[CMD_SEL_B_POS], AVS_WRITEDATA_I[CMD_SEL_A_POS]};
    if ((AVS_READ_I || AVS_WRITE_I) && !r.wait_n)
    begin
      if (AVS_READ_I)
      begin
        next_r.wait_n = 1'b1;
        if (AVS_ADDRESS_I == REG_CMD)
          next_r.rdata = {23'h000000, r.last_cmd};
        else if (AVS_ADDRESS_I == REG_STATUS)
          next_r.rdata = {31'h00000000, busy};
        else
          next_r.rdata = 32'h00000000;
      end
      else if (AVS_ADDRESS_I != REG_CMD)
        next_r.wait_n = 1'b1;                  // Unmapped or status write ignored
      else if (!busy)
      begin
        next_r.wait_n = 1'b1;
        next_r.last_cmd = AVS_WRITEDATA_I[8:0];
        // Word bit k at index k; bias msb is bit 6
        next_r.word = {1'b1,
                       parity_bit(pay) ^ AVS_WRITEDATA_I[CMD_BADPAR_POS],
                       pay[4], pay[5], pay[6], pay[7], pay[2], pay[3], pay[1], pay[0],
                       1'b1, 1'b0};
        next_r.st = ST_LOW;
        next_r.bit_n = 4'h0;
        next_r.div = 8'h00;
      end
    end
    // Data changes while clock low, sampled on rising edge
    case (r.st)
      ST_IDLE:
      begin
        next_r.lclk = 1'b0;
        next_r.ldat = 1'b1;
      end
      ST_LOW:
      begin
        next_r.lclk = 1'b0;
        next_r.ldat = r.word[r.bit_n];
        next_r.div = r.div + 8'h01;
        if (r.div == 8'(HALF_CYC - 1))
        begin
          next_r.div = 8'h00;
          next_r.st = ST_HIGH;
        end
      end
      ST_HIGH:
      begin
        next_r.lclk = 1'b1;
        next_r.div = r.div + 8'h01;
        if (r.div == 8'(HALF_CYC - 1))
        begin
          next_r.div = 8'h00;
          next_r.bit_n = r.bit_n + 4'h1;
          next_r.st = (r.bit_n == 4'(WORD_BITS - 1)) ? ST_IDLE : ST_LOW;
        end
      end
      default:
        next_r.st = ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge CLK_I)
  begin
    if (!RST_B_I)
    begin
      r.st <= ST_IDLE;
      r.div <= 8'h00;
      r.bit_n <= 4'h0;
      r.word <= 12'h000;
      r.lclk <= 1'b0;
      r.ldat <= 1'b1;
      r.rdata <= 32'h00000000;
      r.wait_n <= 1'b0;
      r.last_cmd <= 9'h000;
    end
    else
      r <= next_r;
  end

  assign AVS_READDATA_O = r.rdata;
  assign AVS_WAITREQUEST_O = ~r.wait_n;
  assign link.link_clk = r.lclk;
  assign link.link_data = r.ldat;
endmodule

// ==== ldsc_props.sv ====
// Checker: device-end properties watched at the serial link
`timescale 1ns/1ps
module ldsc_props
  import ldsc_pkg::*;
(
  // Link and device reset
  input wire logic       link_clk,
  input wire logic       link_data,
  input wire logic       RST_B_I,
  // Device outputs
  input ldsc_mode_t      MODE_A_O,
  input wire logic [3:0] BIAS_A_O,
  input ldsc_mode_t      MODE_B_O,
  input wire logic [3:0] BIAS_B_O,
  input wire logic       WORD_OK_O,
  input wire logic       WORD_BAD_O
);
  logic [11:0] sh;
  // Last twelve link bits; a finished word has its first bit in sh[11]
  always_ff @(posedge link_clk)
  begin
    sh <= {sh[10:0], link_data};
  end
  default clocking @(posedge link_clk); endclocking
  default disable iff (!RST_B_I);
  // Start pair, odd parity over bits 2 to 10, high stop
  sequence good_word;
    sh[11:10] == 2'b01 && ^sh[9:1] && sh[0];
  endsequence
  a_ok_framed: assert property (WORD_OK_O |-> good_word)
    else $error("word applied without a valid frame");
  a_bad_framed: assert property (WORD_BAD_O |-> !(sh[0] && ^sh[9:1]))
    else $error("good word rejected");
  a_pulse_one: assert property (WORD_OK_O || WORD_BAD_O |=> !WORD_OK_O && !WORD_BAD_O)
    else $error("result pulse too long");
  a_port_a_load: assert property (WORD_OK_O && sh[9] |->
    {MODE_A_O, BIAS_A_O} == sh[7:2]) else $error("port A not loaded");
  a_port_b_load: assert property (WORD_OK_O && sh[8] |->
    {MODE_B_O, BIAS_B_O} == sh[7:2]) else $error("port B not loaded");
  a_port_a_keep: assert property (WORD_OK_O && !sh[9] |-> $stable({MODE_A_O, BIAS_A_O}))
    else $error("unselected port A changed");
  a_port_b_keep: assert property (WORD_OK_O && !sh[8] |-> $stable({MODE_B_O, BIAS_B_O}))
    else $error("unselected port B changed");
  a_only_on_ok: assert property (!WORD_OK_O |->
    $stable({MODE_A_O, BIAS_A_O, MODE_B_O, BIAS_B_O})) else $error("settings changed alone");
  a_reset_zero: assert property ($rose(RST_B_I) |->
    {MODE_A_O, BIAS_A_O, MODE_B_O, BIAS_B_O, WORD_OK_O, WORD_BAD_O} == 14'h0000)
    else $error("outputs not zero after reset");
endmodule

// ==== line_driver_serial_config_tb.sv ====
// Testbench: host and device ends joined over the configuration link
`timescale 1ns/1ps
module line_driver_serial_config_tb;
  import ldsc_pkg::*;
  logic        clk = 0, lclk = 0, rst_b = 0, rst_d_b = 0, rd = 0, wr = 0;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic        wreq, ok, bad;
  ldsc_mode_t  md_a, md_b;
  logic [3:0]  bs_a, bs_b;
  logic [5:0]  exp_a = 6'h00, exp_b = 6'h00;
  int          err_count = 0, checks = 0;
  ldsc_if h_if ();
  ldsc_if d_if ();
  // Free clock reaches the device only in its reset; afterwards the link stands still between words
  assign d_if.link_clk  = rst_d_b ? h_if.link_clk : lclk;
  assign d_if.link_data = rst_d_b ? h_if.link_data : 1'b1;
  initial forever #12.5 clk = ~clk;
  initial forever #15 lclk = ~lclk;
  ldsc_host i_ldsc_host (.CLK_I(clk), .RST_B_I(rst_b), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdat), .AVS_READDATA_O(q), .AVS_WAITREQUEST_O(wreq),
    .link(h_if.host));
  ldsc_device i_ldsc_device (.link(d_if.device), .RST_B_I(rst_d_b), .MODE_A_O(md_a),
    .BIAS_A_O(bs_a), .MODE_B_O(md_b), .BIAS_B_O(bs_b), .WORD_OK_O(ok), .WORD_BAD_O(bad));
  ldsc_props i_ldsc_props (.link_clk(d_if.link_clk), .link_data(d_if.link_data),
    .RST_B_I(rst_d_b), .MODE_A_O(md_a), .BIAS_A_O(bs_a), .MODE_B_O(md_b), .BIAS_B_O(bs_b),
    .WORD_OK_O(ok), .WORD_BAD_O(bad));
  task automatic end_sim;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One Avalon transfer; a stalled write simply waits, bounded against a hang
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    wr <= w;
    rd <= !w;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wreq !== 1'b0 && n < 3000);
    if (n >= 3000)
    begin
      chk(0, 1);
      end_sim;
    end
    rdat = q;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  // Send one word, wait until the host is idle, then judge both ports
  task automatic send(input logic [8:0] cmd);
    int n;
    n = 0;
    bus(1'b1, REG_CMD, {23'h0, cmd});
    do
    begin
      bus(1'b0, REG_STATUS, 32'h0);
      n++;
    end
    while (rdat[0] !== 1'b0 && n < 300);
    if (n >= 300)
    begin
      chk(0, 1);
      end_sim;
    end
    if (!cmd[8] && cmd[0])
      exp_a = {cmd[3:2], cmd[7:4]};
    if (!cmd[8] && cmd[1])
      exp_b = {cmd[3:2], cmd[7:4]};
    chk({ok, bad, md_a, bs_a, md_b, bs_b}, {!cmd[8], cmd[8], exp_a, exp_b});
  endtask
  task automatic t_reset;
    @(posedge clk);
    chk({ok, bad, md_a, bs_a, md_b, bs_b}, 0);
  endtask
  // Every mode on port A; modes that ignore the bias get a zero code
  task automatic t_modes;
    for (int m = 0; m < 4; m++)
      send({1'b0, 4'(m < 2 ? 0 : m * 5), 2'(m), 2'b01});
  endtask
  task automatic t_select;
    send(9'h0BA);
    send(9'h0EF);
    send(9'h07C);
  endtask
  task automatic t_parity;
    send(9'h1CB);
  endtask
  // Second write stalls behind the first word
  task automatic t_back;
    bus(1'b1, REG_CMD, 32'h0000009D);
    exp_a = 6'h39;
    send(9'h06A);
  endtask
  task automatic t_regs;
    bus(1'b0, REG_CMD, 32'h0);
    chk(rdat, 32'h0000006A);
    bus(1'b0, 4'hC, 32'h0);
    chk(rdat, 32'h00000000);
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge lclk);
    rst_d_b <= 1'b1;
    t_reset;
    t_modes;
    t_select;
    t_parity;
    t_back;
    t_regs;
    end_sim;
  end
endmodule
